// ===== rtl/ps_cfg_ctrl.v
// passive serial configuration control, device side
// Functional notes
// - power-on hold about 100 ms first
// - during hold: health low, user pins released
// - user pins released until configuration completes
// - phases: reset, loading, initialization in order
// - stay in reset while start or health low
// - start high: leave reset, release health line
// - health released means ready for data
// - initialization waits for shared load-complete high
// - error pulls health low, chain reconfigures
// - auto-restart releases health within 40 us
// - user-clock option clocks initialization externally
`timescale 1ns/1ps
`default_nettype none
`include "ps_cfg_map.vh"
module ps_cfg_ctrl #(
    parameter integer POR_CYCLES    = `POR_CYCLES,
    parameter integer AUTO_RST_CYC  = `AUTO_RST_CYCLES,
    parameter integer INIT_CYCLES   = `INIT_CYCLES_DEF,
    parameter integer STREAM_BITS   = `BITSTREAM_LEN_DEF
) (
    input  wire I_MCLK,
    input  wire I_SRST,
    input  wire I_CFG_START_N,
    input  wire I_HEALTH_FLAG_N,
    input  wire I_LOAD_COMPLETE,
    input  wire I_SERIAL_LOAD_CLOCK,
    input  wire I_SERIAL_LOAD_BIT,
    input  wire I_INIT_USER_CLOCK,
    input  wire I_USE_USER_CLOCK,
    input  wire I_AUTO_RESTART,
    input  wire I_CHAIN_ENABLE_IN_N,
    output wire O_HEALTH_FLAG_N_O,
    output wire O_HEALTH_FLAG_N_OE_N,
    output wire O_LOAD_COMPLETE_O,
    output wire O_LOAD_COMPLETE_OE_N,
    output wire O_CHAIN_ENABLE_OUT_N,
    output wire O_USER_IO_OE_N,
    output wire O_USER_MODE,
    output wire O_STREAM_BIT,
    output wire O_STREAM_BIT_VALID
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    wire start_n;
    wire health_n;
    wire done_in;
    wire lclk_lvl;
    wire bit_lvl;
    wire uclk_lvl;
    wire ce_n_lvl;
    wire use_uclk;
    wire auto_rst;
    reg  lclk_prev_reg;
    reg  uclk_prev_reg;
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_start_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_CFG_START_N),
        .o_level (start_n)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_health_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_HEALTH_FLAG_N),
        .o_level (health_n)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_done_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_LOAD_COMPLETE),
        .o_level (done_in)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_lclk_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_SERIAL_LOAD_CLOCK),
        .o_level (lclk_lvl)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_bit_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_SERIAL_LOAD_BIT),
        .o_level (bit_lvl)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_uclk_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_INIT_USER_CLOCK),
        .o_level (uclk_lvl)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_HIGH)
    ) u_ce_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_CHAIN_ENABLE_IN_N),
        .o_level (ce_n_lvl)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_use_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_USE_USER_CLOCK),
        .o_level (use_uclk)
    );
    ps_cfg_sync2 #(
        .RESET_LEVEL (`PIN_IDLE_LOW)
    ) u_auto_sync (
        .i_clk   (I_MCLK),
        .i_srst  (I_SRST),
        .i_pin   (I_AUTO_RESTART),
        .o_level (auto_rst)
    );
    // edge detectors start at the idle low level of both clocks
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            lclk_prev_reg <= `PIN_IDLE_LOW;
            uclk_prev_reg <= `PIN_IDLE_LOW;
        end else begin
            lclk_prev_reg <= lclk_lvl;
            uclk_prev_reg <= uclk_lvl;
        end
    end
    wire lclk_rise = lclk_lvl & ~lclk_prev_reg;
    wire uclk_rise = uclk_lvl & ~uclk_prev_reg;
    wire chain_on  = ~ce_n_lvl;
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    localparam [2:0] ST_POR       = `ST_POR;
    localparam [2:0] ST_RESET     = `ST_RESET;
    localparam [2:0] ST_LOAD      = `ST_LOAD;
    localparam [2:0] ST_WAIT_DONE = `ST_WAIT_DONE;
    localparam [2:0] ST_INIT      = `ST_INIT;
    localparam [2:0] ST_USER      = `ST_USER;
    localparam [2:0] ST_ERROR     = `ST_ERROR;
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [31:0] count_reg;
    reg [31:0] count_next;
    reg        start_prev_reg;
    wire       start_rise = start_n & ~start_prev_reg;
    // init clock source: user clock when selected, else own clock
    wire       init_tick = use_uclk ? uclk_rise : 1'b1;
    // last bit of stream arriving
    wire       last_bit = lclk_rise &&
                          (count_reg == STREAM_BITS - 1);
    // error: load clock runs while the chain enable is off
    wire       load_err = lclk_rise && !chain_on;
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_POR: begin
                if (count_reg == POR_CYCLES - 1) begin
                    state_next = ST_RESET;
                    count_next = 32'h0;
                end else begin
                    count_next = count_reg + 32'h1;
                end
            end
            ST_RESET: begin
                count_next = 32'h0;
                if (start_n && health_n) begin
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (!start_n || !health_n) begin
                    state_next = ST_RESET;
                end else if (load_err) begin
                    state_next = ST_ERROR;
                    count_next = 32'h0;
                end else if (last_bit) begin
                    state_next = ST_WAIT_DONE;
                    count_next = 32'h0;
                end else if (lclk_rise) begin
                    count_next = count_reg + 32'h1;
                end
            end
            ST_WAIT_DONE: begin
                if (!start_n || !health_n) begin
                    state_next = ST_RESET;
                end else if (done_in) begin
                    state_next = ST_INIT;
                end
            end
            ST_INIT: begin
                if (!start_n || !health_n) begin
                    state_next = ST_RESET;
                end else if (init_tick) begin
                    if (count_reg == INIT_CYCLES - 1) begin
                        state_next = ST_USER;
                    end else begin
                        count_next = count_reg + 32'h1;
                    end
                end
            end
            ST_USER: begin
                if (!start_n) begin
                    state_next = ST_RESET;
                end
            end
            ST_ERROR: begin
                if (start_rise) begin
                    state_next = ST_RESET;
                    count_next = 32'h0;
                end else if (auto_rst) begin
                    if (count_reg == AUTO_RST_CYC - 1) begin
                        state_next = ST_RESET;
                        count_next = 32'h0;
                    end else begin
                        count_next = count_reg + 32'h1;
                    end
                end
            end
            default: begin
                state_next = ST_POR;
                count_next = 32'h0;
            end
        endcase
    end
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            state_reg      <= ST_POR;
            count_reg      <= 32'h0;
            start_prev_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            count_reg      <= count_next;
            start_prev_reg <= start_n;
        end
    end
    // ------------------------------------------------------------
    // data capture and outputs
    // ------------------------------------------------------------
    // a bit is taken only while loading with both lines up and chain on
    wire capture_ok = (state_reg == ST_LOAD) && lclk_rise &&
                      start_n && health_n && chain_on;
    reg  stream_bit_reg;
    reg  stream_valid_reg;
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            stream_bit_reg   <= 1'b0;
            stream_valid_reg <= 1'b0;
        end else begin
            stream_valid_reg <= capture_ok;
            if (capture_ok) begin
                stream_bit_reg <= bit_lvl;
            end
        end
    end
    assign O_STREAM_BIT       = stream_bit_reg;
    assign O_STREAM_BIT_VALID = stream_valid_reg;
    // health low in hold, reset by start line, or error
    wire hold_health = (state_reg == ST_POR) ||
                       (state_reg == ST_ERROR) ||
                       ((state_reg == ST_RESET) && !start_n);
    assign O_HEALTH_FLAG_N_O    = 1'b0;
    assign O_HEALTH_FLAG_N_OE_N = ~hold_health;
    // load-complete held low until the stream is in
    assign O_LOAD_COMPLETE_O    = 1'b0;
    assign O_LOAD_COMPLETE_OE_N = (state_reg == ST_WAIT_DONE) ||
                                  (state_reg == ST_INIT) ||
                                  (state_reg == ST_USER);
    assign O_CHAIN_ENABLE_OUT_N = ~O_LOAD_COMPLETE_OE_N;
    assign O_USER_MODE          = (state_reg == ST_USER);
    assign O_USER_IO_OE_N       = ~O_USER_MODE;
endmodule // ps_cfg_ctrl

// ------------------------------------------------------------
// two flip-flop synchroniser for one pin
// ------------------------------------------------------------
module ps_cfg_sync2 #(
    parameter [0:0] RESET_LEVEL = `PIN_IDLE_LOW
) (
    input  wire i_clk,
    input  wire i_srst,
    input  wire i_pin,
    output wire o_level
);
    reg meta_reg;
    reg level_reg;
    always @(posedge i_clk) begin
        if (i_srst) begin
            meta_reg  <= RESET_LEVEL;
            level_reg <= RESET_LEVEL;
        end else begin
            meta_reg  <= i_pin;
            level_reg <= meta_reg;
        end
    end
    assign o_level = level_reg;
endmodule // ps_cfg_sync2
`default_nettype wire

// ===== rtl/ps_cfg_map.vh
// constants for the passive serial configuration control block
`ifndef PS_CFG_MAP_VH
`define PS_CFG_MAP_VH
`define POR_TIME_MS       100
`define AUTO_RST_TIME_US  40
`define CLK_MHZ           200
`define POR_CYCLES        (`POR_TIME_MS * 1000 * `CLK_MHZ)
`define AUTO_RST_CYCLES   (`AUTO_RST_TIME_US * `CLK_MHZ)
`define INIT_CYCLES_DEF   32
`define BITSTREAM_LEN_DEF 64
`define PIN_IDLE_LOW      1'b0
`define PIN_IDLE_HIGH     1'b1
`define ST_POR            3'h0
`define ST_RESET          3'h1
`define ST_LOAD           3'h2
`define ST_WAIT_DONE      3'h3
`define ST_INIT           3'h4
`define ST_USER           3'h5
`define ST_ERROR          3'h6
`endif

// ===== dv/ps_cfg_chk.sv
// checker for passive serial configuration control
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_chk (
    input wire logic I_MCLK,
    input wire logic I_SRST,
    input wire logic I_CFG_START_N,
    input wire logic I_LOAD_COMPLETE,
    input wire logic O_HEALTH_FLAG_N_O,
    input wire logic O_HEALTH_FLAG_N_OE_N,
    input wire logic O_LOAD_COMPLETE_O,
    input wire logic O_LOAD_COMPLETE_OE_N,
    input wire logic O_USER_IO_OE_N,
    input wire logic O_USER_MODE,
    input wire logic O_STREAM_BIT,
    input wire logic O_STREAM_BIT_VALID
);
default clocking @(posedge I_MCLK); endclocking
default disable iff (I_SRST);
a_reset_pulls_health: assert property (disable iff (1'b0)
    I_SRST |=> !O_HEALTH_FLAG_N_OE_N && O_USER_IO_OE_N) else $error("por");
a_pins_follow_mode: assert property (
    !O_USER_IO_OE_N |-> O_USER_MODE && O_LOAD_COMPLETE_OE_N &&
    O_HEALTH_FLAG_N_OE_N) else $error("user pins");
a_done_after_stream: assert property (
    $rose(O_LOAD_COMPLETE_OE_N) |-> O_STREAM_BIT_VALID)
    else $error("load complete early");
a_start_low_holds: assert property (
    !I_CFG_START_N [*6] |-> !O_HEALTH_FLAG_N_OE_N) else $error("start");
a_valid_one_cycle: assert property (
    O_STREAM_BIT_VALID |=> !O_STREAM_BIT_VALID) else $error("valid");
a_bit_stands: assert property (
    !$past(I_SRST) && $changed(O_STREAM_BIT) |-> O_STREAM_BIT_VALID)
    else $error("bit moved");
a_load_when_ready: assert property (
    O_STREAM_BIT_VALID |-> O_HEALTH_FLAG_N_OE_N && !O_USER_MODE)
    else $error("bit outside load");
a_user_after_done: assert property (
    $rose(O_USER_MODE) |-> O_LOAD_COMPLETE_OE_N && $past(I_LOAD_COMPLETE, 3))
    else $error("early user mode");
a_drain_data_low: assert property (
    !O_HEALTH_FLAG_N_O && !O_LOAD_COMPLETE_O) else $error("drain data");
c_bit: cover property (O_STREAM_BIT_VALID);
c_user: cover property ($rose(O_USER_MODE));
c_pull: cover property ($fell(O_HEALTH_FLAG_N_OE_N));
endmodule // ps_cfg_chk
bind ps_cfg_ctrl ps_cfg_chk u_chk (.*);
`default_nettype wire

// ===== dv/ps_cfg_host.sv
// host model driving the start line and the serial load stream
`timescale 1ns/1ps
`default_nettype none
module ps_cfg_host (
    output logic o_start_n,
    output logic o_lclk,
    output logic o_lbit
);
initial begin
    o_start_n = 1'b0;
    o_lclk = 1'b0;
    o_lbit = 1'b0;
end
// a zero width only raises the start line
task automatic restart(input int low_ns);
    if (low_ns > 0) begin
        o_start_n = 1'b0;
        #(low_ns);
    end
    o_start_n = 1'b1;
endtask
// lsb first, load clock runs only inside the frame
task automatic send(input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) begin
        o_lbit = d[i];
        #40 o_lclk = 1'b1;
        #40 o_lclk = 1'b0;
    end
    o_lbit = ~o_lbit;
endtask
endmodule // ps_cfg_host
`default_nettype wire

// ===== dv/test_passive_serial_config_control.sv
// self-checking bench for passive serial configuration control
`timescale 1ns/1ps
`default_nettype none
module test_passive_serial_config_control;
localparam int NB = 16;
localparam int NI = 8;
logic clk, srst, x_h, x_d, uclk, use_u, ar_en, ce_n;
wire logic st_n, lclk, lbit, h_o, h_oe, d_o, d_oe, ceo_n, io_oe, um, sb, sv;
wire logic h_n = (h_oe ? 1'b1 : h_o) & x_h;
wire logic dn = (d_oe ? 1'b1 : d_o) & x_d;
int n_errors, samples_checked, nbits;
logic [15:0] cap;
ps_cfg_host host (.o_start_n(st_n), .o_lclk(lclk), .o_lbit(lbit));
ps_cfg_ctrl #(.POR_CYCLES(50), .AUTO_RST_CYC(20), .INIT_CYCLES(NI),
    .STREAM_BITS(NB)) dut (.I_MCLK(clk), .I_SRST(srst),
    .I_CFG_START_N(st_n), .I_HEALTH_FLAG_N(h_n), .I_LOAD_COMPLETE(dn),
    .I_SERIAL_LOAD_CLOCK(lclk), .I_SERIAL_LOAD_BIT(lbit),
    .I_INIT_USER_CLOCK(uclk), .I_USE_USER_CLOCK(use_u),
    .I_AUTO_RESTART(ar_en), .I_CHAIN_ENABLE_IN_N(ce_n),
    .O_HEALTH_FLAG_N_O(h_o), .O_HEALTH_FLAG_N_OE_N(h_oe),
    .O_LOAD_COMPLETE_O(d_o), .O_LOAD_COMPLETE_OE_N(d_oe),
    .O_CHAIN_ENABLE_OUT_N(ceo_n), .O_USER_IO_OE_N(io_oe),
    .O_USER_MODE(um), .O_STREAM_BIT(sb), .O_STREAM_BIT_VALID(sv));
initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
end
always @(posedge clk) begin
    if (srst) begin
        cap <= 16'h0;
        nbits <= 0;
    end else if (sv) begin
        cap <= {sb, cap[15:1]};
        nbits <= nbits + 1;
    end
end
task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task automatic load(input logic [15:0] d);
    int n0;
    n0 = nbits;
    host.send(d, NB);
    cyc(8);
    chk("bits", 16'(nbits - n0), 16'(NB));
    chk("data", cap, d);
    chk("done oe", 16'(d_oe), 16'h1);
    chk("chain out", 16'(ceo_n), 16'h0);
endtask
task automatic restart();
    host.restart(2000);
    cyc(10);
    chk("released", 16'(h_oe), 16'h1);
endtask
task automatic t_power();
    int n0;
    cyc(10);
    host.restart(0);
    cyc(20);
    chk("por health", 16'(h_oe), 16'h0);
    chk("por pins", 16'(io_oe), 16'h1);
    cyc(40);
    chk("after por", 16'(h_oe), 16'h1);
    x_h = 1'b0;
    n0 = nbits;
    host.send(16'hffff, 4);
    chk("held", 16'(nbits - n0), 16'h0);
    x_h = 1'b1;
endtask
task automatic t_chain();
    x_d = 1'b0;
    load(16'ha5c3);
    cyc(30);
    chk("init held", 16'(um), 16'h0);
    x_d = 1'b1;
    cyc(NI + 10);
    chk("user mode", 16'(um), 16'h1);
    chk("pins on", 16'(io_oe), 16'h0);
endtask
task automatic t_err(input logic ar);
    ar_en = ar;
    restart();
    ce_n = 1'b1;
    host.send(16'h0001, 1);
    ce_n = 1'b0;
    cyc(5);
    chk("error", 16'(h_oe), 16'h0);
    cyc(40);
    chk("auto", 16'(h_oe), 16'(ar));
    if (!ar) restart();
    wait (h_n);
    load(16'h3c5a);
endtask
task automatic t_uclk();
    use_u = 1'b1;
    restart();
    load(16'h8001);
    cyc(40);
    chk("uclk wait", 16'(um), 16'h0);
    repeat (NI + 2) begin
        uclk = 1'b1;
        cyc(4);
        uclk = 1'b0;
        cyc(4);
    end
    chk("uclk entry", 16'(um), 16'h1);
endtask
task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
initial begin
    {srst, x_h, x_d, uclk, use_u, ar_en, ce_n} = 7'h70;
    n_errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    t_power();
    t_chain();
    t_err(1'b1);
    t_err(1'b0);
    t_uclk();
    conclude();
end
initial begin
    #400000;
    n_errors++;
    conclude();
end
endmodule // test_passive_serial_config_control
`default_nettype wire
